// *** orm_pin_mux.sv ***
// Purpose: Over-range flags on the four status pins, with reference clock copies on pins C and D
// Assumes: Reference clocks sampled as levels on clk_i; inputs synchronous
// Notes: Mode and divide changes are applied only at low output phase
//
// Contract
// [R1] Each channel flag goes high while its input exceeds the threshold.
// [R2] A raised flag stays high at least the programmed hold length.
// [R3] Channel B needs dual or quad; channels C, D need quad variant.
// [R4] Pin C carries a clock only when selected and PLL enable high.
// [R5] Select zero or override-disabled makes pin C carry channel C flag. With override enabled, code gives pin C the override clock at select zero.
// [R6] Pin C clock: code 1 undivided, 2 halved, 3 quartered.
// [R7] Pin C clock present from reset, straps alone, no register access.
// [R8] Any select bit set gives pin D undivided clock from startup.
// [R9] Pin D halved or quartered only through register override.
// [R10] Pin D gives a clock only while pin C gives a clock.
// [R11] Select zero or override-disabled makes pin D carry channel D flag. With override enabled, code gives pin D the override clock at select zero.
// [R12] Power-down stops reference repeat and pin C and D clocks.
// [R13] PLL enable high turns PLL on; low disables and bypasses it.
// [R14] Reference repeat copies selected reference, differential or single-ended; code copies it only while PLL enable high.
// [R15] Mode and ratio switches happen without runt pulses.
`default_nettype none
module orm_pin_mux
  import orm_pkg::*;
#(
  parameter int unsigned THR_W = ORM_THR_W,
  parameter int unsigned HOLD_W = ORM_HOLD_W,
  parameter logic [1:0] VARIANT = ORM_VARIANT_QUAD
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] sample_valid_i,
  input wire logic [4*THR_W-1:0] magnitude_i,
  input wire logic [THR_W-1:0] range_limit_threshold_i,
  input wire logic [HOLD_W-1:0] range_flag_hold_length_i,
  input wire logic [1:0] clock_option_select_i,
  input wire logic clk_ovr_en_i,
  input wire logic clk_ovr_disable_i,
  input wire logic [1:0] clk_ovr_sel_c_i,
  input wire logic [1:0] clk_ovr_sel_d_i,
  input wire logic pll_enable_i,
  input wire logic ref_select_se_i,
  input wire logic ref_clock_diff_i,
  input wire logic ref_clock_se_i,
  input wire logic power_down_pin_i,
  output logic pll_active_o,
  output logic pll_bypass_o,
  output logic ref_clock_repeat_out_o,
  output logic over_range_flag_a_o,
  output logic over_range_flag_b_o,
  output logic over_range_flag_c_or_clock_o,
  output logic over_range_flag_d_or_clock_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Detectors
  logic [3:0] flag;
  logic [3:0] chan_en;

  // [R3] Variant gating
  assign chan_en = {(VARIANT == ORM_VARIANT_QUAD), (VARIANT == ORM_VARIANT_QUAD),
                    (VARIANT != ORM_VARIANT_SINGLE), 1'b1} & {4{!power_down_pin_i}};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_det
      orm_flag_if #(.THR_W(THR_W)) fi ();
      assign fi.sample_valid = sample_valid_i[g];
      assign fi.magnitude = magnitude_i[g*THR_W +: THR_W];
      assign flag[g] = fi.flag;
      // [R1] [R2] Threshold and hold
      orm_detect #(.THR_W(THR_W), .HOLD_W(HOLD_W)) u_det (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(chan_en[g]),
        .range_limit_threshold_i(range_limit_threshold_i),
        .range_flag_hold_length_i(range_flag_hold_length_i),
        .chan(fi)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock selection and dividers
  logic ref_sel;
  logic ref_ff;
  logic nxt_ref;
  logic ref_rise;
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic pll_ok;

  // [R13] PLL enable and bypass
  assign pll_active_o = pll_enable_i && !power_down_pin_i;
  assign pll_bypass_o = !pll_enable_i;
  assign pll_ok = pll_enable_i && !power_down_pin_i;

  // [R14] Selected reference repeat
  assign ref_sel = ref_select_se_i ? ref_clock_se_i : ref_clock_diff_i;
  assign ref_rise = ref_sel && !ref_ff;

  always_comb
  begin
    nxt_ref = ref_sel;
    nxt_div = div_ff;
    if (ref_rise)
    begin
      nxt_div = div_ff + 2'h1;
    end
    if (!pll_ok)
    begin
      nxt_div = ORM_DIV_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_ff <= 1'b0;
      div_ff <= ORM_DIV_RST;
    end
    else
    begin
      ref_ff <= nxt_ref;
      div_ff <= nxt_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin C and D selection
  logic [1:0] req_c;
  logic [1:0] req_d;
  logic [1:0] sel_c_ff;
  logic [1:0] sel_d_ff;
  logic [1:0] nxt_sel_c;
  logic [1:0] nxt_sel_d;
  logic clk_c;
  logic clk_d;
  logic out_c;
  logic out_d;
  logic out_ref;
  logic out_a;
  logic out_b;
  logic out_c_ff;
  logic out_d_ff;
  logic out_ref_ff;
  logic out_a_ff;
  logic out_b_ff;

  function automatic logic pick_clk(input logic [1:0] sel, input logic r,
                                    input logic [1:0] d);
    logic v;
    v = 1'b0;
    unique case (sel)
      ORM_SEL_FLAG: v = 1'b0;
      ORM_SEL_DIV1: v = r;
      ORM_SEL_DIV2: v = d[0];
      ORM_SEL_DIV4: v = d[1];
    endcase
    return v;
  endfunction : pick_clk

  ////////////////////////////////////////////////////////////////////////////
  // Requested pin modes from straps, override and gating
  always_comb
  begin
    req_c = ORM_SEL_FLAG;
    req_d = ORM_SEL_FLAG;
    // [R7] [R8] Straps act from reset
    if (clock_option_select_i != ORM_SEL_FLAG)
    begin
      req_c = clock_option_select_i;
      req_d = ORM_SEL_DIV1;
    end
    // [R9] Override ratio for D
    if (clk_ovr_en_i)
    begin
      req_c = clk_ovr_sel_c_i;
      req_d = clk_ovr_sel_d_i;
    end
    // [R5] [R11] Disable returns flags
    if (clk_ovr_disable_i)
    begin
      req_c = ORM_SEL_FLAG;
      req_d = ORM_SEL_FLAG;
    end
    // [R4] [R12] PLL enable and power-down gate clocks
    if (!pll_ok || VARIANT != ORM_VARIANT_QUAD)
    begin
      req_c = ORM_SEL_FLAG;
    end
    // [R10] D clock only with C clock
    if (req_c == ORM_SEL_FLAG)
    begin
      req_d = ORM_SEL_FLAG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin C mode and output
  always_comb
  begin
    nxt_sel_c = sel_c_ff;
    // [R15] Switch only at low output phase
    if (!out_c_ff && (req_c == ORM_SEL_FLAG || !pick_clk(req_c, ref_sel, nxt_div)))
    begin
      nxt_sel_c = req_c;
    end
    // [R10] Leave clock mode only after pin D has left,
    // so pin D never clocks alone
    if (sel_c_ff != ORM_SEL_FLAG && nxt_sel_c == ORM_SEL_FLAG && sel_d_ff != ORM_SEL_FLAG)
    begin
      nxt_sel_c = sel_c_ff;
    end
    // [R6] Pin C clock ratios
    clk_c = pick_clk(nxt_sel_c, ref_sel, nxt_div);
    out_c = (nxt_sel_c == ORM_SEL_FLAG) ? flag[2] : clk_c;
  end

  // Pin C registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_c_ff <= ORM_SEL_FLAG;
      out_c_ff <= 1'b0;
    end
    else
    begin
      sel_c_ff <= nxt_sel_c;
      out_c_ff <= out_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin D mode and output
  always_comb
  begin
    nxt_sel_d = sel_d_ff;
    // [R15] Switch only at low output phase
    if (!out_d_ff && (req_d == ORM_SEL_FLAG || !pick_clk(req_d, ref_sel, nxt_div)))
    begin
      nxt_sel_d = req_d;
    end
    // [R10] Enter clock mode only once pin C
    // already carries a clock
    if (sel_d_ff == ORM_SEL_FLAG && (sel_c_ff == ORM_SEL_FLAG || nxt_sel_c == ORM_SEL_FLAG))
    begin
      nxt_sel_d = ORM_SEL_FLAG;
    end
    // [R8] [R9] Pin D clock ratios
    clk_d = pick_clk(nxt_sel_d, ref_sel, nxt_div);
    out_d = (nxt_sel_d == ORM_SEL_FLAG) ? flag[3] : clk_d;
  end

  // Pin D registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sel_d_ff <= ORM_SEL_FLAG;
      out_d_ff <= 1'b0;
    end
    else
    begin
      sel_d_ff <= nxt_sel_d;
      out_d_ff <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag A, flag B and reference repeat
  always_comb
  begin
    // [R12] [R14] Repeat output gating
    out_ref = pll_ok && ref_sel;
    out_a = flag[0];
    out_b = flag[1];
  end

  // Plain output registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_ref_ff <= 1'b0;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end
    else
    begin
      out_ref_ff <= out_ref;
      out_a_ff <= out_a;
      out_b_ff <= out_b;
    end
  end

  assign ref_clock_repeat_out_o = out_ref_ff;
  assign over_range_flag_a_o = out_a_ff;
  assign over_range_flag_b_o = out_b_ff;
  assign over_range_flag_c_or_clock_o = out_c_ff;
  assign over_range_flag_d_or_clock_o = out_d_ff;
endmodule : orm_pin_mux
`default_nettype wire

// *** orm_pkg.sv ***
// Purpose: Shared constants and types for the over-range and clock-out pin mux
// Assumes: One 20 MHz clock, asynchronous active-low reset
// Notes: Reference clock arrives as a sampled level; dividers run on clk_i
`default_nettype none
package orm_pkg;
  localparam int unsigned ORM_CLK_HZ = 20000000;
  localparam int unsigned ORM_THR_W = 12;
  localparam int unsigned ORM_HOLD_W = 8;
  localparam logic [1:0] ORM_SEL_FLAG = 2'h0;
  localparam logic [1:0] ORM_SEL_DIV1 = 2'h1;
  localparam logic [1:0] ORM_SEL_DIV2 = 2'h2;
  localparam logic [1:0] ORM_SEL_DIV4 = 2'h3;
  localparam logic [1:0] ORM_DIV_RST = 2'h0;
  localparam logic [7:0] ORM_HOLD_RST = 8'h00;
  localparam logic [1:0] ORM_VARIANT_QUAD = 2'h2;
  localparam logic [1:0] ORM_VARIANT_DUAL = 2'h1;
  localparam logic [1:0] ORM_VARIANT_SINGLE = 2'h0;
  typedef enum logic [1:0] {ORM_MODE_FLAG, ORM_MODE_CLOCK} orm_mode_t;
endpackage : orm_pkg
`default_nettype wire

// *** orm_flag_if.sv ***
// Purpose: Carries one channel's sample and flag between internal modules
// Assumes: Single clock domain
// Notes: Sample is an unsigned magnitude
`default_nettype none
interface orm_flag_if #(parameter int unsigned THR_W = 12);
  logic sample_valid;
  logic [THR_W-1:0] magnitude;
  logic flag;
  modport src (output sample_valid, output magnitude, input flag);
  modport det (input sample_valid, input magnitude, output flag);
endinterface : orm_flag_if
`default_nettype wire

// *** orm_detect.sv ***
// Purpose: Over-range detector with minimum pulse hold for one channel
// Assumes: Threshold and hold length are static or slowly changed
// Notes: Hold counts clock cycles after the last exceeding sample
`default_nettype none
module orm_detect
  import orm_pkg::*;
#(
  parameter int unsigned THR_W = ORM_THR_W,
  parameter int unsigned HOLD_W = ORM_HOLD_W
)(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic [THR_W-1:0] range_limit_threshold_i,
  input wire logic [HOLD_W-1:0] range_flag_hold_length_i,
  orm_flag_if.det chan
);
  logic [HOLD_W-1:0] hold_ff;
  logic [HOLD_W-1:0] nxt_hold;
  logic flag_ff;
  logic nxt_flag;
  logic over;

  always_comb
  begin
    over = enable_i && chan.sample_valid && (chan.magnitude > range_limit_threshold_i);
    nxt_hold = hold_ff;
    nxt_flag = flag_ff;
    if (over)
    begin
      nxt_flag = 1'b1;
      nxt_hold = range_flag_hold_length_i;
    end
    else if (hold_ff != '0)
    begin
      nxt_hold = hold_ff - 1'b1;
    end
    else
    begin
      nxt_flag = 1'b0;
    end
    if (!enable_i)
    begin
      nxt_flag = 1'b0;
      nxt_hold = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hold_ff <= '0;
      flag_ff <= 1'b0;
    end
    else
    begin
      hold_ff <= nxt_hold;
      flag_ff <= nxt_flag;
    end
  end

  assign chan.flag = flag_ff;
endmodule : orm_detect
`default_nettype wire

// *** orm_pin_mux_monitor.sv ***
// Purpose: Port checker for the over-range and clock-out pin mux
// Assumes: Design default widths, one clock domain
// Notes: Bound to the design from the test top
`default_nettype none
module orm_pin_mux_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] sample_valid_i,
  input wire logic [47:0] magnitude_i,
  input wire logic [11:0] range_limit_threshold_i,
  input wire logic [7:0] range_flag_hold_length_i,
  input wire logic [1:0] clock_option_select_i,
  input wire logic clk_ovr_en_i,
  input wire logic clk_ovr_disable_i,
  input wire logic pll_enable_i,
  input wire logic ref_select_se_i,
  input wire logic ref_clock_diff_i,
  input wire logic ref_clock_se_i,
  input wire logic power_down_pin_i,
  input wire logic pll_active_o,
  input wire logic pll_bypass_o,
  input wire logic ref_clock_repeat_out_o,
  input wire logic over_range_flag_a_o,
  input wire logic over_range_flag_c_or_clock_o,
  input wire logic over_range_flag_d_or_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] run_ff;
  logic [15:0] nxt_run;
  logic flag_mode;
  assign flag_mode = clk_ovr_disable_i | (!clk_ovr_en_i & (clock_option_select_i == 2'h0));
  always_comb nxt_run = over_range_flag_a_o ? run_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) run_ff <= 16'h0000;
    else run_ff <= nxt_run;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_over_a;
    sample_valid_i[0] && magnitude_i[11:0] > range_limit_threshold_i && !power_down_pin_i
      ##1 !power_down_pin_i [*2];
  endsequence
  sequence s_over_c;
    sample_valid_i[2] && magnitude_i[35:24] > range_limit_threshold_i && !power_down_pin_i
      && flag_mode ##1 (!power_down_pin_i && flag_mode) [*2];
  endsequence
  a_pll_active_level: assert property (pll_active_o == (pll_enable_i && !power_down_pin_i))
    else $error("pll active level wrong");
  a_pll_bypass_level: assert property (pll_bypass_o == !pll_enable_i)
    else $error("pll bypass level wrong");
  a_pd_ref_low: assert property ($past(power_down_pin_i) |-> !ref_clock_repeat_out_o)
    else $error("reference repeat runs in power down");
  a_ref_copy_sel: assert property ($past(rstn_i && pll_enable_i && !power_down_pin_i) |->
    ref_clock_repeat_out_o == $past(ref_select_se_i ? ref_clock_se_i : ref_clock_diff_i))
    else $error("reference repeat does not follow selected input");
  a_flag_a_rise: assert property (s_over_a |-> over_range_flag_a_o)
    else $error("flag a missing two cycles after over sample");
  a_flag_a_hold: assert property ($fell(over_range_flag_a_o) && !power_down_pin_i |->
    run_ff > range_flag_hold_length_i)
    else $error("flag a pulse shorter than hold length");
  a_flag_c_mode: assert property (s_over_c |-> over_range_flag_c_or_clock_o)
    else $error("pin c not carrying flag in flag mode");
  a_pd_pins_low: assert property (power_down_pin_i [*4] |->
    !over_range_flag_c_or_clock_o && !over_range_flag_d_or_clock_o)
    else $error("pin c or d active in power down");
endmodule : orm_pin_mux_monitor
`default_nettype wire

// *** orm_far_end.sv ***
// Purpose: Receiving logic model that counts rising edges on pins
// Assumes: Pins sampled on clk_i
// Notes: clr_i zeroes all counts
`default_nettype none
module orm_far_end (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  input wire logic [2:0] pins_i,
  output logic [2:0][15:0] cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] last_ff;
  logic [2:0][15:0] nxt_cnt;
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      nxt_cnt[k] = clr_i ? 16'h0000 : cnt_o[k] + {15'h0000, pins_i[k] & ~last_ff[k]};
  end
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      last_ff <= 3'h0;
      cnt_o <= '0;
    end
    else
    begin
      last_ff <= pins_i;
      cnt_o <= nxt_cnt;
    end
endmodule : orm_far_end
`default_nettype wire

// *** test_orm_pin_mux.sv ***
// Purpose: Self-checking bench for the pin mux
// Assumes: Reference period of eight clocks
// Notes: Edge counts taken over sixteen reference periods
`default_nettype none
module test_orm_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, rstn_i = 1'h0, clr = 1'h0;
  logic [3:0] sample_valid_i = 4'h0;
  logic [47:0] magnitude_i = 48'h0;
  logic [11:0] range_limit_threshold_i = 12'h100;
  logic [7:0] range_flag_hold_length_i = 8'h03;
  logic [1:0] clock_option_select_i = 2'h0, clk_ovr_sel_c_i = 2'h0, clk_ovr_sel_d_i = 2'h0;
  logic clk_ovr_en_i = 1'h0, clk_ovr_disable_i = 1'h0, pll_enable_i = 1'h1;
  logic ref_select_se_i = 1'h0, ref_clock_diff_i = 1'h0, ref_clock_se_i = 1'h0;
  logic power_down_pin_i = 1'h0, pll_active_o, pll_bypass_o, ref_clock_repeat_out_o;
  logic over_range_flag_a_o, over_range_flag_b_o;
  logic over_range_flag_c_or_clock_o, over_range_flag_d_or_clock_o;
  logic [3:0] pins;
  logic [2:0] ph = 3'h0;
  logic [2:0][15:0] cnt;
  int bad_count = 0, checks_done = 0;
  assign pins = {over_range_flag_d_or_clock_o, over_range_flag_c_or_clock_o,
                 over_range_flag_b_o, over_range_flag_a_o};
  orm_pin_mux i_orm_pin_mux (.*);
  orm_far_end i_orm_far_end (.clk_i(clk_i), .rstn_i(rstn_i), .clr_i(clr), .cnt_o(cnt),
    .pins_i({ref_clock_repeat_out_o, over_range_flag_d_or_clock_o, over_range_flag_c_or_clock_o}));
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    ph <= ph + 3'h1;
    ref_clock_diff_i <= ph[2] & ~ref_select_se_i;
    ref_clock_se_i <= ph[2] & ref_select_se_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic t_flag(input int g, input logic [11:0] m, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    @(posedge clk_i);
    sample_valid_i[g] <= 1'h1;
    magnitude_i[g*12+:12] <= m;
    @(posedge clk_i);
    sample_valid_i <= 4'h0;
    repeat (12)
    begin
      @(negedge clk_i);
      n += {15'h0000, pins[g]};
    end
    chk("flag high cycles", n, exp);
  endtask : t_flag
  task automatic t_clk(input logic [1:0] s, input logic [4:0] f, input logic [1:0] sc, sd,
                       input logic [15:0] ec, ed, er);
    @(posedge clk_i);
    clock_option_select_i <= s;
    {clk_ovr_en_i, clk_ovr_disable_i, pll_enable_i, power_down_pin_i, ref_select_se_i} <= f;
    clk_ovr_sel_c_i <= sc;
    clk_ovr_sel_d_i <= sd;
    repeat (64) @(posedge clk_i);
    clr <= 1'h1;
    @(posedge clk_i);
    clr <= 1'h0;
    repeat (128) @(posedge clk_i);
    #1;
    chk("pin c edges", cnt[0], ec);
    chk("pin d edges", cnt[1], ed);
    chk("repeat edges", cnt[2], er);
  endtask : t_clk
  initial
  begin
    #250000;
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'h1;
    for (int g = 0; g < 4; g++)
    begin
      t_flag(g, 12'h101, 16'h0004);
      t_flag(g, 12'h100, 16'h0000);
    end
    t_clk(2'h1, 5'h04, 2'h0, 2'h0, 16'h0010, 16'h0010, 16'h0010);
    t_clk(2'h2, 5'h04, 2'h0, 2'h0, 16'h0008, 16'h0010, 16'h0010);
    t_clk(2'h3, 5'h04, 2'h0, 2'h0, 16'h0004, 16'h0010, 16'h0010);
    t_clk(2'h1, 5'h05, 2'h0, 2'h0, 16'h0010, 16'h0010, 16'h0010);
    t_clk(2'h0, 5'h14, 2'h1, 2'h2, 16'h0010, 16'h0008, 16'h0010);
    t_clk(2'h0, 5'h14, 2'h0, 2'h1, 16'h0000, 16'h0000, 16'h0010);
    t_clk(2'h3, 5'h0c, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0010);
    t_clk(2'h1, 5'h00, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000);
    t_clk(2'h1, 5'h06, 2'h0, 2'h0, 16'h0000, 16'h0000, 16'h0000);
    final_report();
  end
endmodule : test_orm_pin_mux
bind orm_pin_mux orm_pin_mux_monitor i_orm_pin_mux_monitor (.*);
`default_nettype wire
